// ===== logic/awrw_sequencer.v
// Purpose: activation, boot decision, resets, sleep wake-up, watchdog and timer
// Assumes: core reports run completion and watchdog clears as one-cycle pulses
// Notes: one clock; base tick stands in for the 10 kHz oscillator
`timescale 1ns/10ps
`include "awrw_consts.vh"
// Function
// - activate on reset, end of measurement or sleep wake; reset wins
// - every activation starts execution at the ROM entry address
// - after reset, config-copy flag decides whether config is copied to RAM
// - after reset, power-up-program flag runs user code at 48 or stops
// - non-reset activation starts measurement or restarts counter, then user flag
// - stopping the core fully resets it and its start flags, RAM kept
// - power-on reset resets the chip except RAM, the watchdog-off flag, the tick dividers and rtc_o, then maybe user code
// - four starts without watchdog clear cause a chip reset that keeps the timer
// - watchdog timeout shown at status bit 17
// - stand-alone mode: select pin is reset input, its inverted level at bit 18
// - sleep mode wakes the core regularly without measuring
// - sleep wake-up start shown at status bit 22
// - sleep mode bit equals averaging rate zero
// - eight-bit conversion count comes from config 0 bits 23 to 16
// - in sleep the counter runs out then user code at 48 starts
// - counter runs always; rate is tick over 64 over count
// - watchdog counts measurement starts, forcing reset on missed watchdog clears
// - host may switch watchdog off; pin edges clear the watchdog
// - 24-bit timer steps every 12.8 ms, read at 254, refreshed per measurement
// - reset-cause and sleep-versus-measure flags available to user code
module awrw_sequencer (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire por_i,
  input wire base_tick_i,
  input wire [23:0] cfg0_i,
  input wire [23:0] cfg1_i,
  input wire avrate_zero_i,
  input wire cfg_copy_flag_i,
  input wire pwr_prg_flag_i,
  input wire usr_prg_flag_i,
  input wire host_interface_select_i,
  input wire select_or_reset_pin_i,
  input wire wdt_off_cmd_i,
  input wire wdt_clear_i,
  input wire meas_done_i,
  input wire core_stop_i,
  output reg core_run_o,
  output reg [15:0] core_pc_o,
  output reg core_load_pc_o,
  output reg core_reset_o,
  output reg cfg_copy_o,
  output reg meas_start_o,
  output reg cnv_restart_o,
  output reg chip_reset_o,
  output reg [23:0] status_o,
  output reg reset_cause_o,
  output reg sleep_wake_flag_o,
  output reg [23:0] rtc_o
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_ROM = 6'b000010;
  localparam ST_CFG = 6'b000100;
  localparam ST_DECIDE = 6'b001000;
  localparam ST_USER = 6'b010000;
  localparam ST_STOP = 6'b100000;

  reg [5:0] state_q;
  reg [5:0] state_d;
  reg cause_rst_q;
  reg cause_wake_q;
  reg [2:0] wdt_q;
  reg wdt_off_q;
  reg wdt_alarm_q;
  reg pin_q;
  reg rst_pend_q;
  reg meas_pend_q;
  reg wake_pend_q;
  reg [23:0] rtc_cnt_q;
  reg [31:0] rtc_div_q;
  reg por_seen_q;
  wire sleep_mode;
  wire [7:0] cnv_cnt;
  wire pre_pulse;
  wire cnv_pulse;
  wire pin_edge;
  wire btn_reset;
  wire wdt_fire;

  assign sleep_mode = cfg1_i[`AWRW_CFG1_SLEEP_BIT] | avrate_zero_i;
  assign cnv_cnt = cfg0_i[`AWRW_CFG0_CNV_LSB +: 8];
  assign pin_edge = pin_q ^ select_or_reset_pin_i;
  // the pin is active low as a button; only in stand-alone mode
  assign btn_reset = ~host_interface_select_i & ~select_or_reset_pin_i;
  // the fourth unacknowledged start trips the watchdog, with no fifth start needed
  assign wdt_fire = ~wdt_off_q & (wdt_q == `AWRW_WDT_LIMIT);

  // base tick divided by 64, then by the conversion count
  awrw_prescale #(.W(7)) u_pre (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(ce_i),
    .step_i(base_tick_i),
    .restart_i(1'b0),
    .div_i(`AWRW_PRE_DIV),
    .pulse_o(pre_pulse)
  );
  awrw_prescale #(.W(8)) u_cnv (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(ce_i),
    .step_i(pre_pulse),
    .restart_i(cnv_restart_o),
    .div_i(cnv_cnt),
    .pulse_o(cnv_pulse)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rst_pend_q | meas_pend_q | wake_pend_q) begin
          state_d = ST_ROM;
        end
      end
      ST_ROM: begin
        if (cause_rst_q) begin
          state_d = ST_CFG;
        end else begin
          state_d = ST_DECIDE;
        end
      end
      ST_CFG: state_d = ST_DECIDE;
      ST_DECIDE: begin
        if (cause_rst_q) begin
          state_d = pwr_prg_flag_i ? ST_USER : ST_STOP;
        end else begin
          state_d = usr_prg_flag_i ? ST_USER : ST_STOP;
        end
      end
      ST_USER: begin
        if (core_stop_i) begin
          state_d = ST_STOP;
        end
      end
      ST_STOP: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cause_rst_q <= 1'b0;
      cause_wake_q <= 1'b0;
      wdt_q <= 3'h0;
      wdt_off_q <= 1'b0;
      wdt_alarm_q <= 1'b0;
      pin_q <= 1'b1;
      rst_pend_q <= 1'b1;
      meas_pend_q <= 1'b0;
      wake_pend_q <= 1'b0;
      rtc_cnt_q <= 24'h000000;
      rtc_div_q <= 32'h00000000;
      por_seen_q <= 1'b0;
      core_run_o <= 1'b0;
      core_pc_o <= 16'h0000;
      core_load_pc_o <= 1'b0;
      core_reset_o <= 1'b1;
      cfg_copy_o <= 1'b0;
      meas_start_o <= 1'b0;
      cnv_restart_o <= 1'b0;
      chip_reset_o <= 1'b1;
      status_o <= 24'h000000;
      reset_cause_o <= 1'b0;
      sleep_wake_flag_o <= 1'b0;
      rtc_o <= 24'h000000;
    end else if (ce_i) begin
      state_q <= state_d;
      pin_q <= select_or_reset_pin_i;
      core_load_pc_o <= 1'b0;
      cfg_copy_o <= 1'b0;
      meas_start_o <= 1'b0;
      cnv_restart_o <= 1'b0;
      chip_reset_o <= 1'b0;
      core_reset_o <= 1'b0;
      status_o[`AWRW_STAT_BTN_BIT] <= ~select_or_reset_pin_i;
      // a chip reset wipes all but RAM, the watchdog-off flag, the tick dividers, rtc_o and, except on power-on, the timer, and restarts the sequence
      if (por_i | btn_reset | wdt_fire) begin
        chip_reset_o <= 1'b1;
        core_reset_o <= 1'b1;
        core_run_o <= 1'b0;
        state_q <= ST_IDLE;
        rst_pend_q <= 1'b1;
        meas_pend_q <= 1'b0;
        wake_pend_q <= 1'b0;
        wdt_q <= 3'h0;
        wdt_alarm_q <= wdt_fire;
        status_o[`AWRW_STAT_WDT_BIT] <= wdt_fire;
        status_o[`AWRW_STAT_SLEEP_BIT] <= 1'b0;
        if (por_i) begin
          rtc_cnt_q <= 24'h000000;
          rtc_div_q <= 32'h00000000;
          por_seen_q <= 1'b1;
        end
      end else begin
        // events queue while the core is busy; set wins over the clear on take
        if (meas_done_i & ~sleep_mode) begin
          meas_pend_q <= 1'b1;
          rtc_o <= rtc_cnt_q;
        end else if (state_q == ST_IDLE && state_d == ST_ROM && !rst_pend_q) begin
          meas_pend_q <= 1'b0;
        end
        if (cnv_pulse & sleep_mode) begin
          wake_pend_q <= 1'b1;
        end else if (state_q == ST_IDLE && state_d == ST_ROM && !rst_pend_q && !meas_pend_q) begin
          wake_pend_q <= 1'b0;
        end
        // measurements start from the counter outside sleep
        if (cnv_pulse & ~sleep_mode) begin
          meas_start_o <= 1'b1;
          if (~wdt_off_q) begin
            wdt_q <= wdt_q + 3'h1;
          end
        end
        if (wdt_clear_i | pin_edge) begin
          wdt_q <= 3'h0;
        end
        if (wdt_off_cmd_i & host_interface_select_i) begin
          wdt_off_q <= 1'b1;
        end
        if (por_seen_q) begin
          if (rtc_div_q + 32'h1 >= `AWRW_RTC_STEP_CYC) begin
            rtc_div_q <= 32'h00000000;
            rtc_cnt_q <= rtc_cnt_q + 24'h000001;
          end else begin
            rtc_div_q <= rtc_div_q + 32'h1;
          end
        end
        case (state_q)
          ST_IDLE: begin
            if (state_d == ST_ROM) begin
              // reset outranks the two other sources
              cause_rst_q <= rst_pend_q;
              cause_wake_q <= ~rst_pend_q & ~meas_pend_q & wake_pend_q;
              reset_cause_o <= rst_pend_q;
              sleep_wake_flag_o <= ~rst_pend_q & ~meas_pend_q & wake_pend_q;
              status_o[`AWRW_STAT_SLEEP_BIT] <= ~rst_pend_q & ~meas_pend_q & wake_pend_q;
              rst_pend_q <= 1'b0;
              core_run_o <= 1'b1;
              core_pc_o <= `AWRW_ROM_ENTRY;
              core_load_pc_o <= 1'b1;
            end
          end
          ST_CFG: cfg_copy_o <= cfg_copy_flag_i;
          ST_DECIDE: begin
            if (!cause_rst_q) begin
              // measurement restart or, in sleep, counter restart only
              meas_start_o <= ~cause_wake_q;
              cnv_restart_o <= cause_wake_q;
              if (~cause_wake_q & ~wdt_off_q) begin
                wdt_q <= wdt_q + 3'h1;
              end
            end
            if (state_d == ST_USER) begin
              core_pc_o <= `AWRW_USER_ENTRY;
              core_load_pc_o <= 1'b1;
            end
          end
          ST_STOP: begin
            core_run_o <= 1'b0;
            core_reset_o <= 1'b1;
            cause_rst_q <= 1'b0;
            cause_wake_q <= 1'b0;
            reset_cause_o <= 1'b0;
            sleep_wake_flag_o <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// ===== logic/awrw_consts.vh
// Purpose: constants for the wake-up, reset and watchdog sequencer
// Assumes: clk_i is the low-rate system clock at 50 MHz in this build
// Notes: status positions are bit numbers inside status word 224+22
`ifndef AWRW_CONSTS_VH
`define AWRW_CONSTS_VH
`define AWRW_ROM_ENTRY 16'hf000
`define AWRW_USER_ENTRY 16'h0030
`define AWRW_STAT_REG_IDX 8'he0 + 8'h16
`define AWRW_STAT_WDT_BIT 17
`define AWRW_STAT_BTN_BIT 18
`define AWRW_STAT_SLEEP_BIT 22
`define AWRW_CFG0_CNV_LSB 16
`define AWRW_CFG1_SLEEP_BIT 17
`define AWRW_RTC_ADDR 8'hfe
`define AWRW_WDT_LIMIT 3'h4
`define AWRW_PRE_DIV 7'h40
`define AWRW_CLK_NS 20
`define AWRW_RTC_STEP_NS 12800000
`define AWRW_RTC_STEP_CYC (`AWRW_RTC_STEP_NS / `AWRW_CLK_NS)
`define AWRW_CNV_RST 8'h01
`endif

// ===== logic/awrw_prescale.v
// Purpose: divide the tick base by a fixed or loaded count
// Assumes: synchronous active-high reset, clock enable freezes state
// Notes: pulse_o is one cycle wide, registered
`timescale 1ns/10ps
module awrw_prescale #(
  parameter W = 8
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire en_i,
  input wire step_i,
  input wire restart_i,
  input wire [W-1:0] div_i,
  output reg pulse_o
);
  reg [W-1:0] cnt_q;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= {W{1'b0}};
      pulse_o <= 1'b0;
    end else if (en_i) begin
      pulse_o <= 1'b0;
      if (restart_i) begin
        cnt_q <= {W{1'b0}};
      end else if (step_i) begin
        // a divide value of zero acts as one so the counter never stalls
        if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= div_i) begin
          cnt_q <= {W{1'b0}};
          pulse_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ===== sim/awrw_seq_assertions.sv
// Purpose: port checks on the sequencer
// Assumes: one clock, sync reset
// Notes: bound from the bench top
`timescale 1ns/10ps
module awrw_seq_assertions (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire por_i,
  input wire host_interface_select_i,
  input wire select_or_reset_pin_i,
  input wire core_run_o,
  input wire [15:0] core_pc_o,
  input wire core_load_pc_o,
  input wire core_reset_o,
  input wire cfg_copy_o,
  input wire meas_start_o,
  input wire cnv_restart_o,
  input wire chip_reset_o,
  input wire [23:0] status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  rom_entry_a: assert property ($rose(core_run_o) |-> core_load_pc_o && core_pc_o == 16'hf000)
    else $error("run start off rom entry");
  pc_target_a: assert property (core_load_pc_o |-> core_pc_o inside {16'hf000, 16'h0030})
    else $error("bad load address");
  path_excl_a: assert property (!(meas_start_o && cnv_restart_o))
    else $error("measure and restart together");
  btn_reset_a: assert property (ce_i && !host_interface_select_i && !select_or_reset_pin_i
    |=> chip_reset_o)
    else $error("button gave no reset");
  btn_level_a: assert property (ce_i && !host_interface_select_i
    |=> status_o[18] == !$past(select_or_reset_pin_i))
    else $error("button status wrong");
  por_reset_a: assert property (ce_i && por_i |=> chip_reset_o)
    else $error("power-on gave no reset");
  wdt_alarm_a: assert property ($rose(status_o[17]) |-> chip_reset_o)
    else $error("alarm without reset");
  stop_reset_a: assert property ($fell(core_run_o) |-> ##[0:1] core_reset_o)
    else $error("stop without core reset");
  cfg_only_a: assert property (cfg_copy_o |-> core_run_o && !meas_start_o)
    else $error("copy outside reset boot");
endmodule

// ===== sim/awrw_core_model.sv
// Purpose: core stand-in running user code
// Assumes: user code starts on a load of 0030
// Notes: ends each user-code run after a fixed latency
`timescale 1ns/10ps
module awrw_core_model (
  input wire clk_i,
  input wire core_run_i,
  input wire core_load_pc_i,
  input wire [15:0] core_pc_i,
  input wire clr_en_i,
  output reg core_stop_o,
  output reg wdt_clear_o
);
  reg [3:0] cnt_q;
  initial begin
    core_stop_o = 1'b0;
    wdt_clear_o = 1'b0;
    cnt_q = 4'h0;
  end
  always @(posedge clk_i) begin
    core_stop_o <= 1'b0;
    wdt_clear_o <= 1'b0;
    if (!core_run_i) cnt_q <= 4'h0;
    else if (core_load_pc_i && core_pc_i == 16'h0030) cnt_q <= 4'h1;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q + 4'h1;
    // clear comes before the stop, as firmware must
    if (cnt_q == 4'h2) wdt_clear_o <= clr_en_i;
    if (cnt_q == 4'h3) core_stop_o <= 1'b1;
  end
endmodule

// ===== sim/awrw_sequencer_tb.sv
// Purpose: scenario bench for the sequencer
// Assumes: tick pulse every cycle when enabled
// Notes: rtc step too long to reach here
`timescale 1ns/10ps
module awrw_sequencer_tb;
  logic clk_i, sys_rst_i, por_i, tick, host, pin, woff, mdone, ccp, ppr, upr, avz, clr_en;
  logic [23:0] cfg0, cfg1;
  wire run, ld, crst, cfgc, mst, cres, chr, rc, sw, stop, wclr;
  wire [15:0] pc;
  wire [23:0] stat, rtc;
  int bad_count, comparisons, n_rom, n_usr, n_cfg, n_mst, n_res, n_chr, m, e;
  logic s_rc, s_sw, s_wdt, s_btn, s_slp;
  awrw_sequencer dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .por_i(por_i),
    .base_tick_i(tick), .cfg0_i(cfg0), .cfg1_i(cfg1), .avrate_zero_i(avz),
    .cfg_copy_flag_i(ccp), .pwr_prg_flag_i(ppr), .usr_prg_flag_i(upr),
    .host_interface_select_i(host), .select_or_reset_pin_i(pin), .wdt_off_cmd_i(woff),
    .wdt_clear_i(wclr), .meas_done_i(mdone), .core_stop_i(stop), .core_run_o(run),
    .core_pc_o(pc), .core_load_pc_o(ld), .core_reset_o(crst), .cfg_copy_o(cfgc),
    .meas_start_o(mst), .cnv_restart_o(cres), .chip_reset_o(chr), .status_o(stat),
    .reset_cause_o(rc), .sleep_wake_flag_o(sw), .rtc_o(rtc));
  awrw_core_model core_u (.clk_i(clk_i), .core_run_i(run), .core_load_pc_i(ld),
    .core_pc_i(pc), .clr_en_i(clr_en), .core_stop_o(stop), .wdt_clear_o(wclr));
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_rom += (ld === 1'b1 && pc === 16'hf000);
    n_cfg += (cfgc === 1'b1);
    n_mst += (mst === 1'b1);
    n_res += (cres === 1'b1);
    n_chr += (chr === 1'b1);
    s_wdt |= (stat[17] === 1'b1);
    s_btn |= (stat[18] === 1'b1);
    s_slp |= (stat[22] === 1'b1);
    if (ld === 1'b1 && pc === 16'h0030) begin
      n_usr++;
      s_rc = rc;
      s_sw = sw;
    end
  end
  task tk(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task clr;
    {n_rom, n_usr, n_cfg, n_mst, n_res, n_chr} = '0;
    {s_rc, s_sw, s_wdt, s_btn, s_slp} = '0;
  endtask
  task chk(input string w, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (x !== g) begin
      bad_count++;
      $display("FAIL %s exp %0h got %0h", w, x, g);
    end
  endtask
  task rst;
    sys_rst_i = 1;
    tk(3);
    sys_rst_i = 0;
    // skip the first edge, where the counters still see the reset-level pulses
    tk(1);
    clr;
  endtask
  task meas(input int n);
    repeat (n) begin
      mdone = 1;
      tk(1);
      mdone = 0;
      tk(24);
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_boot;
    ccp = 1;
    ppr = 1;
    rst;
    tk(30);
    chk("rom", 1, n_rom);
    chk("cfg", 1, n_cfg);
    chk("usr", 1, n_usr);
    chk("cause", 1, s_rc);
    {ccp, ppr} = 0;
    clr;
    por_i = 1;
    tk(1);
    por_i = 0;
    tk(30);
    chk("por", 1, n_chr > 0);
    chk("cfg0", 0, n_cfg);
    chk("usr0", 0, n_usr);
    chk("run", 0, run);
  endtask
  task t_meas;
    upr = 1;
    clr;
    meas(1);
    chk("rom", 1, n_rom);
    chk("mst", 1, n_mst);
    chk("usr", 1, n_usr);
    chk("cause", 0, s_rc);
    chk("rtc", 0, rtc);
    upr = 0;
    clr;
    meas(1);
    chk("usr0", 0, n_usr);
  endtask
  task t_sleep;
    for (m = 0; m < 2; m++) begin
      rst;
      cfg1 = (m == 0) ? 24'h020000 : 24'h0;
      avz = (m == 1);
      cfg0 = {8'h02 << m, 16'h0};
      upr = 1;
      tick = 1;
      meas(1);
      tk(495);
      e = 520 / (128 << m);
      chk("mst", 0, n_mst);
      chk("rate", 1, n_res == e || n_res == e - 1);
      chk("usr", n_res, n_usr);
      chk("flag", 1, s_sw);
      chk("stat", 1, s_slp);
      tick = 0;
    end
    {cfg1, avz} = 0;
    rst;
  endtask
  task t_wdt;
    clr_en = 0;
    rst;
    meas(4);
    chk("wdt", 1, n_chr > 0);
    chk("alarm", 1, s_wdt);
    clr_en = 1;
    rst;
    meas(6);
    chk("clr", 0, n_chr);
    clr_en = 0;
    host = 1;
    rst;
    meas(3);
    pin = 0;
    tk(1);
    pin = 1;
    tk(1);
    meas(3);
    chk("edge", 0, n_chr);
    rst;
    woff = 1;
    tk(1);
    woff = 0;
    meas(6);
    chk("off", 0, n_chr);
    host = 0;
  endtask
  task t_btn;
    clr;
    pin = 0;
    tk(3);
    pin = 1;
    tk(30);
    chk("btn", 1, n_chr > 0);
    chk("bstat", 1, s_btn);
  endtask
  initial begin
    {sys_rst_i, por_i, tick, woff, mdone, ccp, ppr, upr, avz} = 0;
    {host, pin, clr_en} = 3'b011;
    {cfg0, cfg1} = 0;
    clr;
    tk(1);
    t_boot;
    t_meas;
    t_sleep;
    t_wdt;
    t_btn;
    test_done;
  end
  initial begin
    #400000;
    bad_count++;
    test_done;
  end
endmodule
bind awrw_sequencer awrw_seq_assertions chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .ce_i(ce_i), .por_i(por_i), .host_interface_select_i(host_interface_select_i),
  .select_or_reset_pin_i(select_or_reset_pin_i), .core_run_o(core_run_o),
  .core_pc_o(core_pc_o), .core_load_pc_o(core_load_pc_o), .core_reset_o(core_reset_o),
  .cfg_copy_o(cfg_copy_o), .meas_start_o(meas_start_o), .cnv_restart_o(cnv_restart_o),
  .chip_reset_o(chip_reset_o), .status_o(status_o));
